// ==== design/conv_sched.sv ====
/*
  Conversion scheduler: timed auto conversions, single-shot requests and
  a four-phase handshake to the converter. Assumes ack_s is already
  synchronised and the converter holds its result while ack is high.
*/
`timescale 1ns/100ps
`default_nettype none

module conv_sched
  import thermal_sensor_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic standby,
  input wire logic [7:0] rate,
  input wire logic oneshot,
  // converter handshake
  input wire logic ack_s,
  output logic conv_req,
  output logic busy,
  output logic done
);

  localparam int TW = $clog2(TICK_CYC + 1);

  logic [TW-1:0] tick_cnt_q, tick_cnt_d;
  logic [7:0] ivl_cnt_q, ivl_cnt_d;
  logic req_q, req_d;
  logic ack_p_q;
  logic tick;
  logic due;
  logic [2:0] shift;
  logic [7:0] period;

  always_comb begin
    tick = (tick_cnt_q == TW'(TICK_CYC - 1));
    tick_cnt_d = tick ? '0 : tick_cnt_q + TW'(1);
    // faster rate code, shorter interval; codes above 7 clamp
    shift = RATE_MAX - ((rate > 8'(RATE_MAX)) ? RATE_MAX : rate[2:0]);
    period = 8'h01 << shift;
    busy = req_q | ack_s;
    due = 1'b0;
    ivl_cnt_d = ivl_cnt_q;
    if (standby) begin
      ivl_cnt_d = '0;
    end else if (tick) begin
      if (ivl_cnt_q >= period - 8'h01) begin
        due = 1'b1;
        ivl_cnt_d = '0;
      end else begin
        ivl_cnt_d = ivl_cnt_q + 8'h01;
      end
    end
    req_d = req_q;
    // a trigger while busy is dropped; in standby only the trigger starts one
    if (!busy && (oneshot || due)) begin
      req_d = 1'b1;
    end else if (ack_s) begin
      req_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
      ivl_cnt_q <= '0;
      req_q <= 1'b0;
      ack_p_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      ivl_cnt_q <= ivl_cnt_d;
      req_q <= req_d;
      ack_p_q <= ack_s;
    end
  end

  assign conv_req = req_q;
  assign done = ack_s & ~ack_p_q;

endmodule : conv_sched

`default_nettype wire

// ==== design/pin_sync.sv ====
/*
  Two-flop synchroniser for a group of asynchronous input levels.
  Assumes each bit is a slow level; no bus coherence across bits.
*/
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end

  assign synced = sync_q;

endmodule : pin_sync

`default_nettype wire

// ==== design/smbus_thermal_sensor_slave.sv ====
/*
  Two-wire bus target for an on-package thermal sensor: packet decode,
  command pointer, sensor registers, limit comparison and alert line.
  Assumes open-drain pins resolved outside, a converter with a four-phase
  req/ack handshake, and bus pins sampled by the 200 MHz core clock.
*/
// Summary of operation
// - answer write, read, send, receive, alert-response packets
// - send byte carries only the single-shot trigger
// - receive byte returns last read-byte register, repeatedly; the code returns the register named by the last command byte of any packet
// - write byte: addr, command, data, each acknowledged
// - read byte: command, repeated start, target sends data
// - send byte: addr, command, acknowledged, then stop
// - receive byte: addr read, target sends data
// - alert query returns own address in upper bits
// - 01h reading resets zero; 02h status byte
// - 03h configuration readback; 04h rate resets 02h
// - 07h upper limit 7Fh; 08h lower C9h
// - 09h, 0Ah, 0Dh, 0Eh load the registers
// - code 0Fh starts a conversion at once
// - trigger during a conversion is discarded
// - standby trigger gives exactly one conversion
// - compare reading to limits, drive alert
// - one byte per conversion, one degree per step
// - alarm flags sticky, status read clears if gone
// - config bit 6 selects standby or auto conversion
// - config bit 7 masks alert and query answer; the code keeps driving an alert that was already pending
// - pointer resets to reserved code 00h
`timescale 1ns/100ps
`default_nettype none

module smbus_thermal_sensor_slave
  import thermal_sensor_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT,
  parameter int TICK_CYC = TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // alert pin, open drain
  input wire logic thermal_alert_n_in,
  output logic thermal_alert_n_out,
  output logic thermal_alert_n_oe,
  // converter
  output logic conv_req,
  input wire logic conv_ack,
  input wire logic [7:0] conv_value,
  input wire logic diode_open
);

  pins_t raw_pins;
  pins_t pins;
  logic conv_busy;
  logic conv_done;

  assign raw_pins = '{scl: scl_in, sda: sda_in, conv_ack: conv_ack, diode_open: diode_open};

  pin_sync #(
    .WIDTH($bits(pins_t))
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw(raw_pins),
    .synced(pins)
  );

  // bus engine state
  bus_state_t st_q, st_d;
  bus_state_t after_q, after_d;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] ptr_q, ptr_d;
  logic got_cmd_q, got_cmd_d;
  logic got_data_q, got_data_d;
  logic rs_q, rs_d;
  logic is_ara_q, is_ara_d;
  logic is_status_q, is_status_d;
  logic hack_q, hack_d;
  logic scl_p_q, sda_p_q;

  // sensor registers
  logic [7:0] temp_q, temp_d;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] rate_q, rate_d;
  logic [7:0] hi_q, hi_d;
  logic [7:0] lo_q, lo_d;
  logic hi_flag_q, hi_flag_d;
  logic lo_flag_q, lo_flag_d;
  logic alert_q, alert_d;

  // events between the groups
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic wr_en, oneshot, status_clr, ara_done;
  logic alert_armed;
  status_t status;
  logic [7:0] rd_data;

  assign scl_rise = pins.scl & ~scl_p_q;
  assign scl_fall = ~pins.scl & scl_p_q;
  assign bus_start = pins.scl & scl_p_q & sda_p_q & ~pins.sda;
  assign bus_stop = pins.scl & scl_p_q & ~sda_p_q & pins.sda;
  assign alert_armed = alert_q & ~cfg_q[CFG_MASK_BIT];

  always_comb begin
    status = '0;
    status.busy = conv_busy;
    status.upper_alarm_flag = hi_flag_q;
    status.lower_alarm_flag = lo_flag_q;
    status.open_fault = pins.diode_open;
    // reserved codes read as zero, which the host must treat as invalid
    case (ptr_q)
      CMD_TEMP_RD: rd_data = temp_q;
      CMD_STATUS_RD: rd_data = status;
      CMD_CFG_RD: rd_data = cfg_q;
      CMD_RATE_RD: rd_data = rate_q;
      CMD_HI_RD: rd_data = hi_q;
      CMD_LO_RD: rd_data = lo_q;
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    st_d = st_q;
    after_d = after_q;
    bitcnt_d = bitcnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    cmd_d = cmd_q;
    ptr_d = ptr_q;
    got_cmd_d = got_cmd_q;
    got_data_d = got_data_q;
    rs_d = rs_q;
    is_ara_d = is_ara_q;
    is_status_d = is_status_q;
    hack_d = hack_q;
    wr_en = 1'b0;
    oneshot = 1'b0;
    status_clr = 1'b0;
    ara_done = 1'b0;
    if (bus_start) begin
      // a start after a command byte is the repeated start of a read byte
      st_d = ST_ADDR;
      bitcnt_d = '0;
      rs_d = got_cmd_q;
    end else if (bus_stop) begin
      // command with no data and no repeated start is a send byte
      if (got_cmd_q && !got_data_q && !rs_q && cmd_q == CMD_ONESHOT) begin
        oneshot = 1'b1;
      end
      st_d = ST_IDLE;
      got_cmd_d = 1'b0;
      got_data_d = 1'b0;
      rs_d = 1'b0;
    end else begin
      case (st_q)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], pins.sda};
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl_fall && bitcnt_q == BYTE_BITS) begin
            bitcnt_d = '0;
            st_d = ST_ACK;
            case (st_q)
              ST_ADDR: begin
                if (sh_q[7:1] == DEV_ADDR) begin
                  is_ara_d = 1'b0;
                  is_status_d = (ptr_q == CMD_STATUS_RD);
                  tx_d = rd_data;
                  after_d = sh_q[0] ? ST_TX : ST_CMD;
                end else if (sh_q[7:1] == ARA_ADDR && sh_q[0] && alert_armed) begin
                  is_ara_d = 1'b1;
                  is_status_d = 1'b0;
                  tx_d = {DEV_ADDR, 1'b1};
                  after_d = ST_TX;
                end else begin
                  st_d = ST_IGNORE;
                end
              end
              ST_CMD: begin
                cmd_d = sh_q;
                ptr_d = sh_q;
                got_cmd_d = 1'b1;
                after_d = ST_WDATA;
              end
              default: begin
                // only the first data byte is taken; more are not acknowledged
                wr_en = ~got_data_q;
                got_data_d = 1'b1;
                if (got_data_q) begin
                  st_d = ST_IGNORE;
                end
                after_d = ST_IGNORE;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            st_d = after_q;
            bitcnt_d = '0;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_q == BYTE_BITS) begin
              st_d = ST_HACK;
            end else begin
              tx_d = {tx_q[6:0], 1'b1};
            end
          end
        end
        ST_HACK: begin
          if (scl_rise) begin
            hack_d = ~pins.sda;
            ara_done = is_ara_q;
            status_clr = is_status_q;
          end else if (scl_fall) begin
            // host ack asks for the same register again
            if (hack_q && !is_ara_q) begin
              tx_d = rd_data;
              st_d = ST_TX;
              bitcnt_d = '0;
            end else begin
              st_d = ST_IGNORE;
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          st_d = st_q;
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      after_q <= ST_IDLE;
      bitcnt_q <= '0;
      sh_q <= 8'h00;
      tx_q <= 8'hFF;
      cmd_q <= CMD_NONE;
      ptr_q <= CMD_NONE;
      got_cmd_q <= 1'b0;
      got_data_q <= 1'b0;
      rs_q <= 1'b0;
      is_ara_q <= 1'b0;
      is_status_q <= 1'b0;
      hack_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      st_q <= st_d;
      after_q <= after_d;
      bitcnt_q <= bitcnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      cmd_q <= cmd_d;
      ptr_q <= ptr_d;
      got_cmd_q <= got_cmd_d;
      got_data_q <= got_data_d;
      rs_q <= rs_d;
      is_ara_q <= is_ara_d;
      is_status_q <= is_status_d;
      hack_q <= hack_d;
      scl_p_q <= pins.scl;
      sda_p_q <= pins.sda;
    end
  end

  // open drain: only ever pull low, and switch only while scl is low after a fall
  assign sda_out = 1'b0;
  assign sda_oe = (st_q == ST_ACK) | ((st_q == ST_TX) & ~tx_q[7]);

  conv_sched #(
    .TICK_CYC(TICK_CYC)
  ) u_sched (
    .ref_clk(ref_clk),
    .rst(rst),
    .standby(cfg_q[CFG_STBY_BIT]),
    .rate(rate_q),
    .oneshot(oneshot),
    .ack_s(pins.conv_ack),
    .conv_req(conv_req),
    .busy(conv_busy),
    .done(conv_done)
  );

  // limits are signed so the C9h low limit means minus 55 degrees
  logic set_hi, set_lo, hold_hi, hold_lo;

  always_comb begin
    set_hi = conv_done & ($signed(conv_value) >= $signed(hi_q));
    set_lo = conv_done & ($signed(conv_value) <= $signed(lo_q));
    hold_hi = $signed(temp_q) >= $signed(hi_q);
    hold_lo = $signed(temp_q) <= $signed(lo_q);
    temp_d = conv_done ? conv_value : temp_q;
    cfg_d = cfg_q;
    rate_d = rate_q;
    hi_d = hi_q;
    lo_d = lo_q;
    if (wr_en) begin
      case (cmd_q)
        CMD_CFG_WR: cfg_d = sh_q;
        CMD_RATE_WR: rate_d = sh_q;
        CMD_HI_WR: hi_d = sh_q;
        CMD_LO_WR: lo_d = sh_q;
        default: cfg_d = cfg_q;
      endcase
    end
    // a new alarm wins over the clear of the same cycle
    hi_flag_d = (hi_flag_q & ~(status_clr & ~hold_hi)) | set_hi;
    lo_flag_d = (lo_flag_q & ~(status_clr & ~hold_lo)) | set_lo;
    // masking stops new alerts but does not release a pending one
    alert_d = (alert_q & ~ara_done) | ((set_hi | set_lo) & ~cfg_q[CFG_MASK_BIT]);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      temp_q <= TEMP_RST;
      cfg_q <= CFG_RST;
      rate_q <= RATE_RST;
      hi_q <= HI_RST;
      lo_q <= LO_RST;
      hi_flag_q <= 1'b0;
      lo_flag_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      temp_q <= temp_d;
      cfg_q <= cfg_d;
      rate_q <= rate_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      hi_flag_q <= hi_flag_d;
      lo_flag_q <= lo_flag_d;
      alert_q <= alert_d;
    end
  end

  // the line level is not needed; the wired state is not sensed back
  assign thermal_alert_n_out = 1'b0;
  assign thermal_alert_n_oe = alert_q;

endmodule : smbus_thermal_sensor_slave

`default_nettype wire

// ==== design/thermal_sensor_pkg.sv ====
/*
  Shared constants and types for the bus-attached thermal sensor target:
  command codes, reset values, field positions, timebase and carriers.
  Assumes a single 200 MHz core clock in every user of this package.
*/
package thermal_sensor_pkg;

  // command codes
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_TEMP_RD = 8'h01;
  localparam logic [7:0] CMD_STATUS_RD = 8'h02;
  localparam logic [7:0] CMD_CFG_RD = 8'h03;
  localparam logic [7:0] CMD_RATE_RD = 8'h04;
  localparam logic [7:0] CMD_HI_RD = 8'h07;
  localparam logic [7:0] CMD_LO_RD = 8'h08;
  localparam logic [7:0] CMD_CFG_WR = 8'h09;
  localparam logic [7:0] CMD_RATE_WR = 8'h0A;
  localparam logic [7:0] CMD_HI_WR = 8'h0D;
  localparam logic [7:0] CMD_LO_WR = 8'h0E;
  localparam logic [7:0] CMD_ONESHOT = 8'h0F;

  // values after reset
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h02;
  localparam logic [7:0] HI_RST = 8'h7F;
  localparam logic [7:0] LO_RST = 8'hC9;

  // configuration field positions
  localparam int unsigned CFG_MASK_BIT = 7;
  localparam int unsigned CFG_STBY_BIT = 6;

  // bus addressing; the own address default is arbitrary
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h4C;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // conversion timebase
  localparam int CLK_PERIOD_NS = 5;
  localparam int CONV_TICK_NS = 1000000;
  localparam int TICK_CYCLES = CONV_TICK_NS / CLK_PERIOD_NS;
  localparam logic [2:0] RATE_MAX = 3'h7;

  typedef struct packed {
    logic busy;
    logic [1:0] rsv_hi;
    logic upper_alarm_flag;
    logic lower_alarm_flag;
    logic open_fault;
    logic [1:0] rsv_lo;
  } status_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic conv_ack;
    logic diode_open;
  } pins_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_CMD,
    ST_WDATA,
    ST_TX,
    ST_HACK,
    ST_IGNORE
  } bus_state_t;

endpackage : thermal_sensor_pkg

// ==== tb/smbus_host_model.sv ====
/*
  Bus host model: start, stop, bit transfer and packet tasks.
  Assumes an open-drain data wire with pull-up resolved by the bench.
*/
`timescale 1ns/100ps
`default_nettype none

module smbus_host_model (
  // clock
  input wire logic ref_clk,
  // bus
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : w
  // msb first; a 1 releases the wire
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      scl <= 1'b0;
      w(6);
      sda_pull <= !o[k];
      w(7);
      scl <= 1'b1;
      w(10);
      i[k] = sda;
      w(2);
    end
  endtask : xfer
  task automatic start_c();
    scl <= 1'b0;
    w(6);
    sda_pull <= 1'b0;
    w(7);
    scl <= 1'b1;
    w(6);
    sda_pull <= 1'b1;
    w(6);
  endtask : start_c
  task automatic stop_c();
    scl <= 1'b0;
    w(6);
    sda_pull <= 1'b1;
    w(7);
    scl <= 1'b1;
    w(6);
    sda_pull <= 1'b0;
    w(12);
  endtask : stop_c
  // write byte, or send byte without data
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] v, input logic dat, output logic ok);
    logic [8:0] r0, r1, r2;
    r2 = 9'h000;
    start_c();
    xfer({a, 2'h1}, r0);
    xfer({c, 1'h1}, r1);
    if (dat)
      xfer({v, 1'h1}, r2);
    stop_c();
    ok = !r0[0] && !r1[0] && !r2[0];
  endtask : wr
  // read byte with command, or receive byte and alert query without
  task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic cmd, output logic [7:0] d, output logic ok);
    logic [8:0] r0, r1, r2;
    r0 = 9'h000;
    if (cmd) begin
      start_c();
      xfer({a, 2'h1}, r0);
      xfer({c, 1'h1}, r1);
      r0[0] = r0[0] | r1[0];
    end
    start_c();
    xfer({a, 2'h3}, r1);
    xfer(9'h1FF, r2);
    stop_c();
    d = r2[8:1];
    ok = !r0[0] && !r1[0];
  endtask : rd
endmodule : smbus_host_model

`default_nettype wire

// ==== tb/smbus_thermal_sensor_slave_properties.sv ====
/*
  Concurrent checks on the sensor target's pins and converter handshake.
  Assumes one 200 MHz clock domain and bus pins driven by a slow host.
*/
`timescale 1ns/100ps
`default_nettype none

module smbus_thermal_sensor_slave_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // alert pin
  input wire logic thermal_alert_n_oe,
  // converter
  input wire logic conv_req,
  input wire logic conv_ack
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_ack_up;
    $rose(conv_ack);
  endsequence
  sequence s_req_gone;
    ##[1:6] !conv_req;
  endsequence
  // a pulled-low bit must last far longer than the sync delay
  sequence s_oe_hold;
    sda_oe [*8];
  endsequence

  a_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  a_req_holds: assert property (conv_req && !conv_ack |=> conv_req)
    else $error("request dropped before ack");
  a_req_release: assert property (s_ack_up |-> s_req_gone)
    else $error("request kept after ack");
  a_req_quiet: assert property (conv_ack && !conv_req |=> !conv_req)
    else $error("request raised while ack high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda changed with scl high");
  a_oe_stands: assert property ($rose(sda_oe) |-> s_oe_hold)
    else $error("sda pull too short");
  a_alert_release: assert property ($fell(thermal_alert_n_oe) |-> scl_in && !sda_oe)
    else $error("alert released outside query ack");
  a_alert_cause: assert property ($rose(thermal_alert_n_oe) |-> $past(conv_ack, 2))
    else $error("alert raised without conversion");
endmodule : smbus_thermal_sensor_slave_properties

bind smbus_thermal_sensor_slave smbus_thermal_sensor_slave_properties props_inst (
  .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .thermal_alert_n_oe(thermal_alert_n_oe), .conv_req(conv_req), .conv_ack(conv_ack)
);

`default_nettype wire

// ==== tb/smbus_thermal_sensor_slave_tb.sv ====
/*
  Self-checking bench: reset values, register access, single shots,
  alarms, alert query and auto mode. Assumes host model and checker bind.
*/
`timescale 1ns/100ps
`default_nettype none

module smbus_thermal_sensor_slave_tb
  import thermal_sensor_pkg::*;
;
  localparam logic [6:0] DEV = 7'h4C; // arbitrary own address
  logic ref_clk, rst, conv_req, sda_oe, sda_out, alert_oe, alert_out;
  logic conv_ack = 1'b0;
  logic [7:0] conv_value = 8'h00;
  // early auto conversions must not trip the limits written in t_regs
  logic [7:0] temp_in = 8'h10;
  int failures = 0, cmp_count = 0, conv_n = 0, cd = 0, conv_dly = 3000;
  wire logic scl, pull;
  wire logic sda = !(pull || sda_oe);

  smbus_thermal_sensor_slave #(.DEV_ADDR(DEV), .TICK_CYC(20)) smbus_thermal_sensor_slave_inst (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .thermal_alert_n_in(!alert_oe), .thermal_alert_n_out(alert_out), .thermal_alert_n_oe(alert_oe),
    .conv_req(conv_req), .conv_ack(conv_ack), .conv_value(conv_value), .diode_open(1'b0)
  );
  smbus_host_model host_inst (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(pull));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // converter: slow answer, ack held a few cycles past the request
  always @(posedge ref_clk) begin
    if (conv_req && !conv_ack) begin
      cd = cd + 1;
      if (cd >= conv_dly) begin
        conv_value <= temp_in;
        conv_ack <= 1'b1;
        conv_n = conv_n + 1;
        cd = 0;
      end
    end else if (!conv_req && conv_ack) begin
      cd = cd + 1;
      if (cd >= 3) begin
        conv_ack <= 1'b0;
        cd = 0;
      end
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rb(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host_inst.rd(DEV, c, 1'h1, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, e);
  endtask : rb
  task automatic wb(input logic [7:0] c, input logic [7:0] v, input logic dat);
    logic ok;
    host_inst.wr(DEV, c, v, dat, ok);
    chk({7'h00, ok}, 8'h01);
  endtask : wb
  // waits for conversion count n and an idle handshake
  task automatic settle(input int n);
    for (int i = 0; i < 9000 && (conv_n < n || conv_req || conv_ack); i++)
      @(posedge ref_clk);
  endtask : settle
  // stimulus avoids reserved codes other than the reset pointer 00h, receive after write, trigger in auto
  task automatic t_reset();
    logic [7:0] d;
    logic ok;
    host_inst.rd(DEV, 8'h00, 1'h0, d, ok);
    chk(d, 8'h00);
    rb(CMD_TEMP_RD, TEMP_RST);
    rb(CMD_CFG_RD, CFG_RST);
    rb(CMD_RATE_RD, RATE_RST);
    rb(CMD_HI_RD, HI_RST);
    rb(CMD_LO_RD, LO_RST);
  endtask : t_reset
  task automatic t_regs();
    logic [7:0] d;
    logic ok;
    wb(CMD_CFG_WR, 8'h40, 1'h1);
    wb(CMD_RATE_WR, 8'h05, 1'h1);
    wb(CMD_HI_WR, 8'h28, 1'h1);
    wb(CMD_LO_WR, 8'h06, 1'h1);
    host_inst.wr(DEV ^ 7'h01, CMD_HI_WR, 8'h00, 1'h1, ok);
    chk({7'h00, ok}, 8'h00);
    rb(CMD_CFG_RD, 8'h40);
    rb(CMD_RATE_RD, 8'h05);
    rb(CMD_HI_RD, 8'h28);
    rb(CMD_LO_RD, 8'h06);
    host_inst.rd(DEV, 8'h00, 1'h0, d, ok);
    chk(d, 8'h06);
    host_inst.rd(DEV, 8'h00, 1'h0, d, ok);
    chk(d, 8'h06);
  endtask : t_regs
  task automatic t_oneshot();
    int n;
    settle(0);
    n = conv_n;
    wb(CMD_TEMP_RD, 8'h00, 1'h0);
    chk({7'h00, conv_req}, 8'h00);
    temp_in = 8'h30;
    wb(CMD_ONESHOT, 8'h00, 1'h0);
    chk({7'h00, conv_req}, 8'h01);
    wb(CMD_ONESHOT, 8'h00, 1'h0);
    rb(CMD_STATUS_RD, 8'h80);
    settle(n + 1);
    repeat (3000) @(posedge ref_clk);
    chk(8'(conv_n - n), 8'h01);
    chk({7'h00, alert_oe}, 8'h01);
    rb(CMD_TEMP_RD, 8'h30);
  endtask : t_oneshot
  task automatic t_alarm();
    logic [7:0] d;
    logic ok;
    int n;
    rb(CMD_STATUS_RD, 8'h10);
    rb(CMD_STATUS_RD, 8'h10);
    host_inst.rd(ARA_ADDR, 8'h00, 1'h0, d, ok);
    chk({d[7:1], ok}, {DEV, 1'h1});
    chk({7'h00, alert_oe}, 8'h00);
    temp_in = 8'h10;
    n = conv_n;
    wb(CMD_ONESHOT, 8'h00, 1'h0);
    settle(n + 1);
    rb(CMD_STATUS_RD, 8'h10);
    rb(CMD_STATUS_RD, 8'h00);
    wb(CMD_CFG_WR, 8'hC0, 1'h1);
    temp_in = 8'h06;
    wb(CMD_ONESHOT, 8'h00, 1'h0);
    settle(n + 2);
    chk({7'h00, alert_oe}, 8'h00);
    host_inst.rd(ARA_ADDR, 8'h00, 1'h0, d, ok);
    chk({7'h00, ok}, 8'h00);
    rb(CMD_STATUS_RD, 8'h08);
  endtask : t_alarm
  task automatic t_auto();
    int n;
    conv_dly = 5;
    wb(CMD_RATE_WR, 8'h07, 1'h1);
    wb(CMD_CFG_WR, 8'h00, 1'h1);
    n = conv_n;
    repeat (1000) @(posedge ref_clk);
    chk({7'h00, conv_n - n >= 10}, 8'h01);
    wb(CMD_CFG_WR, 8'h40, 1'h1);
    settle(0);
    n = conv_n;
    repeat (1000) @(posedge ref_clk);
    chk(8'(conv_n - n), 8'h00);
  endtask : t_auto

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    t_reset();
    t_regs();
    t_oneshot();
    t_alarm();
    t_auto();
    test_done();
  end
  // run needs about 40k cycles
  initial begin
    repeat (95000) @(posedge ref_clk);
    failures++;
    test_done();
  end
endmodule : smbus_thermal_sensor_slave_tb

`default_nettype wire
